/* rtl/rcause_defs.svh */
// Constants for the reset cause and brown-out control block.
// Assumes a 100 MHz core clock and an 8-bit register port.
`ifndef RCAUSE_DEFS_SVH
`define RCAUSE_DEFS_SVH

`define CLK_PERIOD_NS 10
`define ADDR_W 4
`define ADDR_CAUSE 4'h0
`define ADDR_STATUS 4'h1

`define BOR_MODE_OFF 2'h0
`define BOR_MODE_SOFT 2'h1
`define BOR_MODE_NOSLEEP 2'h2
`define BOR_MODE_ON 2'h3

`define PRIORITY_LEVELS_ENABLE_BIT 7
`define SOFT_BROWNOUT_ENABLE_BIT 6
`define RI_BIT 4
`define TO_BIT 3
`define PD_BIT 2
`define POR_BIT 1
`define BOR_BIT 0

`define CAUSE_POR_VAL 8'h1C
`define CAUSE_WMASK 8'hD3
`define READ_IDLE 8'h00

`define POWER_UP_TIMER_TICKS 2048
`define OST_TICKS 1024
`define PLL_LOCK_US 2000
`define PLL_LOCK_CYC_DEF ((`PLL_LOCK_US * 1000) / `CLK_PERIOD_NS)
`define PIN_FILT_NS 50
`define PIN_FILT_CYC_DEF ((`PIN_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOR_MIN_NS 1000
`define BOR_MIN_CYC_DEF ((`BOR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 18

`endif

/* rtl/rcause_pkg.sv */
// Types shared by the reset cause and brown-out control block.
// Assumes nothing beyond the constants header.
package rcause_pkg;

    typedef enum logic [2:0] {
        ST_HOLD = 3'h0,
        ST_POWER_UP_TIMER = 3'h1,
        ST_OST = 3'h3,
        ST_PLL = 3'h2,
        ST_RUN = 3'h6
    } seq_state_e;

    typedef struct packed {
        logic priority_levels_enable;
        logic soft_brownout_enable;
        logic unused;
        logic ri;
        logic wdt_to;
        logic pd;
        logic por;
        logic bor;
    } cause_s;

    typedef struct packed {
        logic pin_en;
        logic [1:0] bor_mode;
        logic [1:0] bor_level;
        logic power_up_timer_en_n;
        logic crystal;
        logic pll;
    } boot_cfg_s;

endpackage

/* rtl/stage_timer.sv */
// Up-counter shared by the start-up delay stages.
// Assumes start is a one-cycle pulse and tick is a one-cycle enable.
`timescale 1ns/1ps
module stage_timer #(
    parameter int W = 18
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    output logic done
);
    logic [W-1:0] count_r;
    logic done_r;
    wire logic [W-1:0] count_inc = count_r + W'(1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            done_r <= 1'b0;
        end else if (start) begin
            count_r <= '0;
            done_r <= 1'b0;
        end else if (tick && !done_r) begin
            count_r <= count_inc;
            done_r <= (count_inc == limit);
        end
    end

    assign done = done_r;
endmodule

/* rtl/reset_cause_ctrl.sv */
// Reset supervision: cause register, pin filter, brown-out control
// and the power-up, oscillator start-up and lock delay sequence.
// Assumes all inputs are synchronous to CORE_CLK and that the
// configuration word is static; oscillator ticks are enable pulses.
//
// Contract
// R01: priority enable bit selects priority levels
// R02: soft brown-out enable only in mode 01
// R03: soft enable resets to one in mode 01
// R04: reset instruction clears its flag, resets device
// R05: watchdog flag cleared by time-out, set otherwise
// R06: power-down flag cleared by sleep instruction
// R07: power-on flag cleared by power-on, software sets
// R08: brown-out flag cleared by brown-out, firmware sets
// R09: software sets both flags after power-on
// R10: reset held while pin low, short pulses filtered
// R11: reset pin is never driven
// R12: disabled pin is a plain digital input
// R13: power-on pulse restarts from initialized state
// R14: long brown-out resets until supply recovers
// R15: brown-out during power-up delay restarts it
// R16: brown-out and power-up timer independent
// R17: modes 00 and 11 fixed by hardware
// R18: mode 10 disables detection during sleep
// R19: detection needs stable reference first
// R20: threshold only from configuration field
// R21: power-up timer counts 2048 slow ticks
// R22: power-up timer enabled by low bit
// R23: crystal start-up counts 1024 oscillator cycles
// R24: lock delay follows start-up when PLL on
// R25: watchdog and power-down flags read-only
`include "rcause_defs.svh"
`timescale 1ns/1ps
module reset_cause_ctrl
    import rcause_pkg::*;
#(
    parameter int PLL_LOCK_CYC = `PLL_LOCK_CYC_DEF,
    parameter int PIN_FILT_CYC = `PIN_FILT_CYC_DEF,
    parameter int BOR_MIN_CYC = `BOR_MIN_CYC_DEF
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire boot_cfg_s CFG,
    input wire logic POR_PULSE,
    input wire logic BROWNOUT_DET,
    input wire logic REF_STABLE,
    input wire logic EXT_RESET_PIN,
    input wire logic LF_OSC_TICK,
    input wire logic OSC_IN_TICK,
    input wire logic SLEEP_ACTIVE,
    input wire logic RESET_INSTR,
    input wire logic WDT_CLEAR_INSTR,
    input wire logic SLEEP_INSTR,
    input wire logic WDT_TIMEOUT,
    input wire logic [`ADDR_W-1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic DEVICE_RESET,
    output logic PRIORITY_LEVELS_ENABLE,
    output logic REF_ENABLE,
    output logic BOR_ACTIVE,
    output logic [1:0] BOR_LEVEL,
    output logic PIN_DIG_IN,
    output logic PIN_OUT,
    output logic PIN_OE_N
);
    localparam logic [7:0] PIN_FILT_L = 8'(PIN_FILT_CYC);
    localparam logic [15:0] BOR_MIN_L = 16'(BOR_MIN_CYC);

    cause_s cause_r, cause_nxt;
    seq_state_e state_r, state_nxt;
    logic init_r, cold_r, pin_rst_d_r, bor_hold_r, bor_act_r;
    logic [7:0] pin_cnt_r;
    logic [15:0] bor_cnt_r;
    logic [7:0] rdata_r;
    logic dev_rst_r, priority_levels_enable_out_r, ref_en_r, pin_in_r;
    logic [1:0] level_r;
    logic timer_done;

    wire logic mode_soft = (CFG.bor_mode == `BOR_MODE_SOFT);
    wire logic in_run = (state_r == ST_RUN);
    wire logic wr_cause = REG_WR && (REG_ADDR == `ADDR_CAUSE);
    wire logic rd_cause = REG_RD && (REG_ADDR == `ADDR_CAUSE);
    wire logic rd_status = REG_RD && (REG_ADDR == `ADDR_STATUS);

    // R13: power-on pulse or logic reset release
    wire logic por_evt = POR_PULSE || init_r;

    // R10: filtered low level on the pin
    // R12: pin function gated by its enable
    wire logic pin_rst = CFG.pin_en && (pin_cnt_r == PIN_FILT_L);
    wire logic pin_evt = pin_rst && !pin_rst_d_r;

    // R17: fixed modes ignore the soft enable
    // R18: mode 10 drops detection in sleep
    // R02: soft enable effective only in mode 01
    wire logic bor_en = (CFG.bor_mode == `BOR_MODE_ON)
        || ((CFG.bor_mode == `BOR_MODE_NOSLEEP) && !SLEEP_ACTIVE)
        || (mode_soft && cause_r.soft_brownout_enable);

    // R14: trip after minimum duration
    wire logic bor_trip = (bor_cnt_r == BOR_MIN_L);
    wire logic bor_evt = bor_trip && !bor_hold_r;

    // R04: reset instruction acts only while running
    wire logic rst_instr_evt = RESET_INSTR && in_run;
    wire logic wdt_rst_evt = WDT_TIMEOUT && !SLEEP_ACTIVE && in_run;
    wire logic src_active = por_evt || bor_trip || bor_hold_r
        || pin_rst || rst_instr_evt || wdt_rst_evt;

    // R16: timer enable is its own configuration bit
    // R22: power-up timer enabled when its bit is low
    wire logic need_power_up_timer = cold_r && !CFG.power_up_timer_en_n;
    wire logic need_ost = cold_r && CFG.crystal;
    wire logic need_pll = need_ost && CFG.pll;
    wire seq_state_e after_power_up_timer = need_ost ? ST_OST : ST_RUN;
    wire seq_state_e first_stage = need_power_up_timer ? ST_POWER_UP_TIMER : after_power_up_timer;

    wire logic timer_start = (state_nxt != state_r);
    wire logic timer_tick = (state_r == ST_POWER_UP_TIMER) ? LF_OSC_TICK
        : (state_r == ST_OST) ? OSC_IN_TICK : 1'b1;
    wire logic [`TIMER_W-1:0] timer_limit =
        (state_r == ST_POWER_UP_TIMER) ? `TIMER_W'(`POWER_UP_TIMER_TICKS)
        : (state_r == ST_OST) ? `TIMER_W'(`OST_TICKS)
        : `TIMER_W'(PLL_LOCK_CYC);

    wire logic [7:0] status_w = {state_r, cold_r, bor_hold_r, bor_act_r,
        bor_en, pin_rst};
    // R02: soft enable reads zero outside mode 01
    wire logic [7:0] cause_rd = cause_r & {1'b1, mode_soft, 6'h3F};
    wire logic [7:0] rdata_nxt = rd_cause ? cause_rd
        : rd_status ? status_w : `READ_IDLE;

    always_comb begin
        cause_nxt = cause_r;
        // R25: write mask skips the two read-only flags
        if (wr_cause) begin
            cause_nxt = (cause_r & ~`CAUSE_WMASK)
                | (REG_WDATA & `CAUSE_WMASK);
            cause_nxt.unused = 1'b0;
            if (!mode_soft) begin
                cause_nxt.soft_brownout_enable = cause_r.soft_brownout_enable;
            end
        end
        // R05: clear-watchdog and sleep set the watchdog flag
        // R06: clear-watchdog sets, sleep clears power-down
        if (WDT_CLEAR_INSTR) begin
            cause_nxt.wdt_to = 1'b1;
            cause_nxt.pd = 1'b1;
        end
        if (SLEEP_INSTR) begin
            cause_nxt.wdt_to = 1'b1;
            cause_nxt.pd = 1'b0;
        end
        if (pin_evt && SLEEP_ACTIVE) begin
            cause_nxt.wdt_to = 1'b1;
            cause_nxt.pd = 1'b0;
        end
        // R05: time-out clears the watchdog flag
        if (WDT_TIMEOUT) begin
            cause_nxt.wdt_to = 1'b0;
            if (SLEEP_ACTIVE) begin
                cause_nxt.pd = 1'b0;
            end
        end
        // R04: reset instruction clears its flag
        if (rst_instr_evt) begin
            cause_nxt.ri = 1'b0;
        end
        // R08: brown-out reset clears the brown-out flag
        if (bor_evt) begin
            cause_nxt.ri = 1'b1;
            cause_nxt.wdt_to = 1'b1;
            cause_nxt.pd = 1'b1;
            cause_nxt.bor = 1'b0;
            if (!mode_soft) begin
                cause_nxt.soft_brownout_enable = 1'b0;
            end
        end
        // R03: soft enable reset value from mode
        // R07: power-on clears the power-on flag
        if (por_evt) begin
            cause_nxt = cause_s'(`CAUSE_POR_VAL);
            cause_nxt.soft_brownout_enable = mode_soft;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_HOLD: begin
                state_nxt = first_stage;
            end
            // R21: held in reset while the slow timer runs
            ST_POWER_UP_TIMER: begin
                if (timer_done) begin
                    state_nxt = after_power_up_timer;
                end
            end
            // R23: crystal start-up after the power-up delay
            ST_OST: begin
                if (timer_done) begin
                    state_nxt = need_pll ? ST_PLL : ST_RUN;
                end
            end
            // R24: lock delay closes the sequence
            ST_PLL: begin
                if (timer_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
        // R15: any source, new brown-out included, restarts
        if (src_active) begin
            state_nxt = ST_HOLD;
        end
    end

    stage_timer #(
        .W(`TIMER_W)
    ) u_timer (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .start(timer_start),
        .tick(timer_tick),
        .limit(timer_limit),
        .done(timer_done)
    );

    // R10: pin low counter saturates at the filter length
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_cnt_r <= 8'h00;
            pin_rst_d_r <= 1'b0;
        end else begin
            pin_rst_d_r <= pin_rst;
            if (EXT_RESET_PIN) begin
                pin_cnt_r <= 8'h00;
            end else if (pin_cnt_r != PIN_FILT_L) begin
                pin_cnt_r <= pin_cnt_r + 8'h01;
            end
        end
    end

    // R19: detection waits for a stable reference
    // R14: hold until supply is back above threshold
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bor_act_r <= 1'b0;
            bor_cnt_r <= 16'h0000;
            bor_hold_r <= 1'b0;
        end else begin
            bor_act_r <= bor_en && REF_STABLE;
            if (!(bor_act_r && BROWNOUT_DET)) begin
                bor_cnt_r <= 16'h0000;
            end else if (!bor_trip) begin
                bor_cnt_r <= bor_cnt_r + 16'h0001;
            end
            if (!BROWNOUT_DET) begin
                bor_hold_r <= 1'b0;
            end else if (bor_trip) begin
                bor_hold_r <= 1'b1;
            end
        end
    end

    // The cause register reset value is a constant; the mode-dependent
    // part is applied by the init pulse right after release.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cause_r <= cause_s'(`CAUSE_POR_VAL);
            init_r <= 1'b1;
            cold_r <= 1'b1;
            state_r <= ST_HOLD;
        end else begin
            cause_r <= cause_nxt;
            init_r <= 1'b0;
            state_r <= state_nxt;
            if (por_evt || bor_evt) begin
                cold_r <= 1'b1;
            end else if (in_run) begin
                cold_r <= 1'b0;
            end
        end
    end

    // R11: the pin output is never enabled
    // R20: threshold taken only from configuration
    // R01: priority enable passed to the interrupt logic
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_r <= `READ_IDLE;
            dev_rst_r <= 1'b1;
            priority_levels_enable_out_r <= 1'b0;
            ref_en_r <= 1'b0;
            level_r <= 2'h0;
            pin_in_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            dev_rst_r <= (state_nxt != ST_RUN);
            priority_levels_enable_out_r <= cause_r.priority_levels_enable;
            ref_en_r <= bor_en;
            level_r <= CFG.bor_level;
            pin_in_r <= EXT_RESET_PIN;
        end
    end

    assign REG_RDATA = rdata_r;
    assign DEVICE_RESET = dev_rst_r;
    assign PRIORITY_LEVELS_ENABLE = priority_levels_enable_out_r;
    assign REF_ENABLE = ref_en_r;
    assign BOR_ACTIVE = bor_act_r;
    assign BOR_LEVEL = level_r;
    assign PIN_DIG_IN = pin_in_r;
    assign PIN_OUT = 1'b0;
    assign PIN_OE_N = 1'b1;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_priority_levels_enable_write;
        wr_cause && !por_evt;
    endsequence

    sequence s_pin_held;
        (CFG.pin_en && !EXT_RESET_PIN) [*8];
    endsequence

    a_priority_levels_enable_to_output: assert property ( // R01
        s_priority_levels_enable_write |=> cause_r.priority_levels_enable == $past(REG_WDATA[7])
            ##1 PRIORITY_LEVELS_ENABLE == $past(REG_WDATA[7], 2))
        else $error("priority enable not carried to output");
    a_soft_en_mask: assert property ( // R02
        rd_cause && !mode_soft |=> !REG_RDATA[6])
        else $error("soft enable read nonzero outside mode 01");
    a_soft_en_reset: assert property ( // R03
        por_evt |=> cause_r.soft_brownout_enable == $past(mode_soft))
        else $error("soft enable reset value wrong");
    a_reset_instr: assert property ( // R04
        rst_instr_evt && !por_evt && !bor_evt
            |=> !cause_r.ri && DEVICE_RESET)
        else $error("reset instruction not recorded");
    a_wdt_flag: assert property ( // R05
        WDT_TIMEOUT && !por_evt && !bor_evt |=> !cause_r.wdt_to)
        else $error("watchdog flag not cleared");
    a_pd_sleep: assert property ( // R06
        SLEEP_INSTR && !WDT_CLEAR_INSTR && !por_evt && !bor_evt
            |=> !cause_r.pd)
        else $error("power-down flag not cleared by sleep");
    a_por_no_hw_set: assert property ( // R07
        !cause_r.por && !wr_cause |=> !cause_r.por)
        else $error("power-on flag set by hardware");
    a_pin_reset: assert property ( // R10
        s_pin_held |=> DEVICE_RESET)
        else $error("pin held low without reset");
    a_pin_never_drv: assert property ( // R11
        PIN_OE_N && !PIN_OUT)
        else $error("reset pin driven");
    a_power_up_timer_restart: assert property ( // R15
        state_r == ST_POWER_UP_TIMER && bor_trip |=> state_r == ST_HOLD)
        else $error("brown-out did not restart power-up delay");
    a_power_up_timer_bypass: assert property ( // R22
        state_r == ST_HOLD && CFG.power_up_timer_en_n |=> state_r != ST_POWER_UP_TIMER)
        else $error("power-up timer ran while disabled");
    a_ref_first: assert property ( // R19
        BOR_ACTIVE |-> $past(REF_STABLE) && $past(bor_en))
        else $error("detection active before reference stable");
endmodule

/* verification/supply_model.sv */
// Far-side model: supply monitors, the reset pin and the oscillator ticks.
// Assumes the bench raises its requests as levels on clk edges.
`timescale 1ns/1ps
module supply_model #(
    parameter int REF_DLY = 4
) (
    input wire logic clk,
    input wire logic ref_en,
    input wire logic por_req,
    input wire logic low_req,
    input wire logic pin_low_req,
    output logic por_pulse,
    output logic brownout,
    output logic ref_ok,
    output logic pin,
    output logic lf_tick,
    output logic osc_tick
);
    int ref_cnt;
    initial begin
        ref_cnt = 0;
        {por_pulse, brownout, ref_ok, lf_tick} = 4'h0;
        pin = 1'b1;
    end
    // A fast oscillator input keeps the crystal wait short.
    assign osc_tick = 1'b1;
    always @(posedge clk) begin
        ref_cnt <= ref_en ? ref_cnt + 1 : 0;
        ref_ok <= ref_en && ref_cnt >= REF_DLY;
        lf_tick <= ~lf_tick;
        por_pulse <= por_req;
        brownout <= low_req;
        // The pin idles high through its pull-up.
        pin <= ~pin_low_req;
    end
endmodule

/* verification/reset_cause_ctrl_tb_top.sv */
// Self-checking bench for the reset cause and brown-out control block.
// Assumes the supply model drives the far side and the ticks.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
end
module reset_cause_ctrl_tb_top
    import rcause_pkg::*;
;
    localparam int PLL = 20;
    localparam int T_COLD = 2 * 2048 + 1024 + PLL;
    logic clk;
    logic rstn = 1'b0;
    boot_cfg_s cfg = '0;
    boot_cfg_s c;
    logic [3:0] ev = 4'h0;
    logic sleep = 1'b0;
    logic por_req = 1'b0;
    logic low_req = 1'b0;
    logic pin_low = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rdata, e_v, d;
    logic dev_rst, ple, ref_en, bor_act, pin_in, pin_out, pin_oe_n;
    logic por_p, bod, ref_ok, pin, lf, osc;
    logic [1:0] lvl, lvl_o;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 3472;
    int n;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    supply_model sup (.clk(clk), .ref_en(ref_en), .por_req(por_req),
        .low_req(low_req), .pin_low_req(pin_low), .por_pulse(por_p),
        .brownout(bod), .ref_ok(ref_ok), .pin(pin), .lf_tick(lf),
        .osc_tick(osc));

    reset_cause_ctrl #(.PLL_LOCK_CYC(PLL), .PIN_FILT_CYC(2),
        .BOR_MIN_CYC(3)) dut (
        .CORE_CLK(clk), .RESETN(rstn), .CFG(cfg), .POR_PULSE(por_p),
        .BROWNOUT_DET(bod), .REF_STABLE(ref_ok), .EXT_RESET_PIN(pin),
        .LF_OSC_TICK(lf), .OSC_IN_TICK(osc), .SLEEP_ACTIVE(sleep),
        .RESET_INSTR(ev[0]), .WDT_CLEAR_INSTR(ev[1]),
        .SLEEP_INSTR(ev[2]), .WDT_TIMEOUT(ev[3]), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_RDATA(rdata), .DEVICE_RESET(dev_rst),
        .PRIORITY_LEVELS_ENABLE(ple), .REF_ENABLE(ref_en),
        .BOR_ACTIVE(bor_act), .BOR_LEVEL(lvl_o), .PIN_DIG_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n));

    // Read data stand only in the cycle after the strobe.
    always @(posedge clk) rd_q <= rd_s;
    always @(negedge clk) begin
        `CHK("pin drive", 1'b1, pin_oe_n) // pin never driven
        `CHK("pin out", 1'b0, pin_out) // pin output low
        if (rd_q && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            `CHK("read data", e_v, rdata) // read path
        end else if (rstn) begin
            `CHK("idle read data", 8'h00, rdata) // idle reads zero
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_s <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 4'h0;
    endtask

    task automatic power_on(input boot_cfg_s k);
        @(posedge clk);
        rstn <= 1'b0;
        cfg <= k;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask

    // Every wait is bounded; running out counts as a mismatch.
    task automatic wait_rst(input logic v, input int lim, output int k);
        k = 0;
        while (dev_rst !== v) begin
            @(negedge clk);
            k++;
            if (k > lim) begin
                error_cnt++;
                $display("unexpected wait for reset level %b", v);
                tally_and_finish();
            end
        end
    endtask

    initial begin
        lvl = 2'($random(seed));
        c = '{1'b1, 2'h1, lvl, 1'b0, 1'b1, 1'b1};
        power_on(c);
        repeat (1000) @(posedge clk);
        low_req <= 1'b1;
        repeat (10) @(posedge clk);
        low_req <= 1'b0;
        wait_rst(1'b0, T_COLD + 100, n);
        `CHK("start length", 1'b1, n >= T_COLD - 6 && n <= T_COLD + 40)
        rd(4'h0, 8'h5C); // power-on value
        rd(4'hF, 8'h00);
        rd(4'h1, 8'hC6); // status while running
        repeat (4) begin
            d = 8'($random(seed));
            wr(4'h0, d);
            rd(4'h0, (d & 8'hD3) | 8'h0C); // write mask
        end
        wr(4'h0, 8'h80);
        repeat (2) @(negedge clk);
        `CHK("priority enable", 1'b1, ple) // priority levels
        wr(4'h0, 8'h53);
        repeat (2) @(negedge clk);
        `CHK("priority enable", 1'b0, ple) // single level
        pulse(3);
        @(negedge clk);
        `CHK("watchdog reset", 1'b1, dev_rst) // time-out resets
        wait_rst(1'b0, 10, n);
        rd(4'h0, 8'h57); // time-out flag
        pulse(2);
        rd(4'h0, 8'h5B); // sleep instruction
        pulse(1);
        rd(4'h0, 8'h5F); // clear instruction
        pulse(0);
        @(negedge clk);
        `CHK("instr reset", 1'b1, dev_rst) // instruction resets
        wait_rst(1'b0, 10, n);
        rd(4'h0, 8'h4F); // instruction flag
        $display("test flags done");
        @(posedge clk);
        pin_low <= 1'b1;
        @(posedge clk);
        pin_low <= 1'b0;
        repeat (6) begin
            @(negedge clk);
            `CHK("glitch", 1'b0, dev_rst) // short pulse ignored
        end
        @(posedge clk);
        pin_low <= 1'b1;
        repeat (20) @(negedge clk);
        `CHK("pin reset", 1'b1, dev_rst) // held while low
        @(posedge clk);
        pin_low <= 1'b0;
        wait_rst(1'b0, T_COLD + 100, n);
        rd(4'h0, 8'h4F); // flags kept
        $display("test pin done");
        for (int m = 0; m < 4; m++) begin
            lvl = 2'($random(seed));
            c = '{1'b0, 2'(m), lvl, 1'b1, 1'b0, 1'b0};
            power_on(c);
            wait_rst(1'b0, 40, n); // timer bypassed
            rd(4'h0, {1'b0, m == 1, 6'h1C}); // soft enable value
            wr(4'h0, 8'h40);
            rd(4'h0, {1'b0, m == 1, 6'h0C}); // soft bit gated
            @(posedge clk);
            sleep <= 1'b1;
            repeat (3) @(negedge clk);
            `CHK("enable in sleep", m == 1 || m == 3, ref_en)
            `CHK("level", c.bor_level, lvl_o) // level from config
            @(posedge clk);
            sleep <= 1'b0;
            repeat (2) @(negedge clk);
            `CHK("enable", m != 0, ref_en) // fixed modes
            `CHK("active", m == 1 || m == 3, bor_act) // waits for ref
            if (m == 3) begin
                @(posedge clk);
                pin_low <= 1'b1;
                repeat (10) @(negedge clk);
                `CHK("pin ignored", 1'b0, dev_rst) // plain input
                `CHK("pin input", 1'b0, pin_in) // pin level seen
                @(posedge clk);
                pin_low <= 1'b0;
                repeat (3) @(negedge clk);
                `CHK("pin input high", 1'b1, pin_in) // pin level seen
                wr(4'h0, 8'h13); // software sets flags
                @(posedge clk);
                low_req <= 1'b1;
                repeat (20) @(negedge clk);
                `CHK("brown-out hold", 1'b1, dev_rst) // held low
                @(posedge clk);
                low_req <= 1'b0;
                wait_rst(1'b0, 40, n); // no timer
                rd(4'h0, 8'h1E); // brown-out flag
                @(posedge clk);
                por_req <= 1'b1;
                @(posedge clk);
                por_req <= 1'b0;
                wait_rst(1'b1, 10, n); // power-on pulse
                wait_rst(1'b0, 40, n);
                rd(4'h0, 8'h1C); // power-on flag
            end
            $display("test mode %0d done", m);
        end
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule
